// file: design/plc_pkg.sv
// Functional notes
// - enable low holds outputs low, lock low
// - enable high restarts locking to reference
// - counter clear returns every divider counter
// - clear high keeps outputs cleared, lock low
// - clear release begins a new lock sequence
// - detector enable gates corrections, oscillator runs
// - detector off: outputs keep toggling, may drift
// - user drops detector enable when reference lost
// - switchover request starts manual reference change
// - lock high when locked, low otherwise
// - lock may chatter; single high not final
// - outputs zero, one global; two also pin
// - references come from dedicated clock pins
// - control inputs from fabric logic or pins
// - multiplier, post-scale 1..32; pre-divider 1..4
// - output = input times m over n times C
`default_nettype none

package plc_pkg;

  // ----------------------------------------------------------------
  // divider settings
  // ----------------------------------------------------------------
  localparam int SET_W        = 6;
  localparam int MULT_MIN     = 1;
  localparam int MULT_MAX     = 32;
  localparam int PRE_MIN      = 1;
  localparam int PRE_MAX      = 4;
  localparam int POST_MIN     = 1;
  localparam int POST_MAX     = 32;
  localparam int MULT_DEFAULT = 4;
  localparam int PRE_DEFAULT  = 1;
  localparam int POST_DEFAULT = 2;

  // ----------------------------------------------------------------
  // timing model
  // ----------------------------------------------------------------
  localparam int PERIOD_W          = 16;
  localparam int LOCK_REF_CYCLES   = 16;
  localparam int LOCK_W            = 8;
  localparam int STABLE_CYCLES     = 32;
  localparam int STABLE_W          = 8;
  localparam int PIN_SYNC_STAGES   = 3;
  localparam int NUM_OUTPUTS       = 3;

  // ----------------------------------------------------------------
  // lock tracking states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LOCK_OFF     = 2'b00,
    LOCK_ACQUIRE = 2'b01,
    LOCK_LOCKED  = 2'b10
  } plc_lock_state_type;

endpackage

`default_nettype wire

// file: design/plc_link_if.sv
`default_nettype none

interface plc_link_if;
  logic pllEnable;
  logic counterClear;
  logic pfdEnable;
  logic switchRequest;
  logic lockIndicator;
  logic scaledOutZero;
  logic scaledOutOne;
  logic scaledOutTwo;

  // ----------------------------------------------------------------
  // one view per party
  // ----------------------------------------------------------------
  modport device (
    input  pllEnable,
    input  counterClear,
    input  pfdEnable,
    input  switchRequest,
    output lockIndicator,
    output scaledOutZero,
    output scaledOutOne,
    output scaledOutTwo
  );

  modport user (
    output pllEnable,
    output counterClear,
    output pfdEnable,
    output switchRequest,
    input  lockIndicator,
    input  scaledOutZero,
    input  scaledOutOne,
    input  scaledOutTwo
  );
endinterface

`default_nettype wire

// file: design/plc_device_end.sv
`default_nettype none

module plc_device_end
  import plc_pkg::*;
#(
  parameter int MULT_SETTING  = MULT_DEFAULT,
  parameter int PRE_SETTING   = PRE_DEFAULT,
  parameter int POST0_SETTING = POST_DEFAULT,
  parameter int POST1_SETTING = POST_DEFAULT,
  parameter int POST2_SETTING = POST_DEFAULT
) (
  input  wire logic     sys_clk,
  input  wire logic     rst_n,
  input  wire logic     refClkPrimaryPin,
  input  wire logic     refClkSecondaryPin,
  plc_link_if.device    link,
  output logic          extClkOut,
  output logic          refSelSecondary
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // settings outside the legal range are pinned to the nearest bound
  function automatic logic [SET_W-1:0] clampSetting(input int value, input int lo, input int hi);
    int v;
    v = value;
    if (v < lo) begin
      v = lo;
    end else if (v > hi) begin
      v = hi;
    end
    return v[SET_W-1:0];
  endfunction

  localparam logic [SET_W-1:0] MULT_SET = clampSetting(MULT_SETTING, MULT_MIN, MULT_MAX);
  localparam logic [SET_W-1:0] PRE_SET  = clampSetting(PRE_SETTING, PRE_MIN, PRE_MAX);
  localparam logic [SET_W-1:0] POST_SET [NUM_OUTPUTS] = '{
    clampSetting(POST0_SETTING, POST_MIN, POST_MAX),
    clampSetting(POST1_SETTING, POST_MIN, POST_MAX),
    clampSetting(POST2_SETTING, POST_MIN, POST_MAX)
  };
  localparam logic [PERIOD_W-1:0] VCO_STEP = {{(PERIOD_W-SET_W-1){1'b0}}, MULT_SET, 1'b0};
  localparam logic [LOCK_W-1:0]   LOCK_LAST = LOCK_W'(LOCK_REF_CYCLES - 1);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [PIN_SYNC_STAGES-1:0] syncPrimary_reg;
  logic [PIN_SYNC_STAGES-1:0] syncSecondary_reg;
  logic [1:0]                 refLevel_reg;
  logic [1:0]                 refLevelPrev_reg;
  logic                       refRise;
  logic                       holdOff;
  logic                       switchPrev_reg;
  logic                       switchEvent;
  logic                       refSel_reg;
  logic [SET_W-1:0]           preCount_reg;
  logic                       refTick;
  logic [PERIOD_W-1:0]        periodCount_reg;
  logic [PERIOD_W-1:0]        refPeriod_reg;
  logic [PERIOD_W-1:0]        phaseAcc_reg;
  logic [PERIOD_W:0]          phaseSum;
  logic                       vcoHalf_reg;
  logic [SET_W-1:0]           postCount_reg [NUM_OUTPUTS];
  logic [NUM_OUTPUTS-1:0]     outLevel_reg;
  logic                       extLevel_reg;
  plc_lock_state_type         lockState_reg;
  logic [LOCK_W-1:0]          lockCount_reg;
  logic                       lock_reg;

  // either control ends the loop: outputs cleared, counters reset, lock lost
  assign holdOff = !link.pllEnable || link.counterClear;

  // ----------------------------------------------------------------
  // reference pins
  // ----------------------------------------------------------------
  // reference pins are foreign to sys_clk; three stages, accept when the last two agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncPrimary_reg   <= '0;
      syncSecondary_reg <= '0;
    end else begin
      syncPrimary_reg   <= {syncPrimary_reg[PIN_SYNC_STAGES-2:0], refClkPrimaryPin};
      syncSecondary_reg <= {syncSecondary_reg[PIN_SYNC_STAGES-2:0], refClkSecondaryPin};
    end
  end

  // filtered level only moves when the last two stages agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refLevel_reg     <= 2'h0;
      refLevelPrev_reg <= 2'h0;
    end else begin
      if (syncPrimary_reg[1] == syncPrimary_reg[2]) begin
        refLevel_reg[0] <= syncPrimary_reg[2];
      end
      if (syncSecondary_reg[1] == syncSecondary_reg[2]) begin
        refLevel_reg[1] <= syncSecondary_reg[2];
      end
      refLevelPrev_reg <= refLevel_reg;
    end
  end

  assign refRise = refLevel_reg[refSel_reg] && !refLevelPrev_reg[refSel_reg];

  // ----------------------------------------------------------------
  // manual switchover
  // ----------------------------------------------------------------
  // a rising request flips the source; lock is re-acquired on the new one
  assign switchEvent = link.switchRequest && !switchPrev_reg;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      switchPrev_reg <= 1'b0;
      refSel_reg     <= 1'b0;
    end else begin
      switchPrev_reg <= link.switchRequest;
      if (switchEvent) begin
        refSel_reg <= !refSel_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // pre-divider
  // ----------------------------------------------------------------
  assign refTick = refRise && (preCount_reg == PRE_SET - 6'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCount_reg <= '0;
    end else if (holdOff) begin
      preCount_reg <= '0;
    end else if (refTick) begin
      preCount_reg <= '0;
    end else if (refRise) begin
      preCount_reg <= preCount_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // phase detector: reference period in sys_clk cycles
  // ----------------------------------------------------------------
  // with the detector off the last period is kept, so the oscillator free-runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      periodCount_reg <= '0;
      refPeriod_reg   <= '0;
    end else if (holdOff) begin
      periodCount_reg <= '0;
      refPeriod_reg   <= '0;
    end else if (refTick) begin
      periodCount_reg <= '0;
      if (link.pfdEnable && periodCount_reg != '0) begin
        refPeriod_reg <= periodCount_reg + 16'h0001;
      end
    end else if (periodCount_reg != '1) begin
      periodCount_reg <= periodCount_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // oscillator: 2*m half periods per reference period
  // ----------------------------------------------------------------
  // limitation: the modelled oscillator cannot exceed half the sys_clk rate
  assign phaseSum = {1'b0, phaseAcc_reg} + {1'b0, VCO_STEP};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseAcc_reg <= '0;
      vcoHalf_reg  <= 1'b0;
    end else if (holdOff || refPeriod_reg == '0) begin
      phaseAcc_reg <= '0;
      vcoHalf_reg  <= 1'b0;
    end else if (phaseSum >= {1'b0, refPeriod_reg}) begin
      phaseAcc_reg <= PERIOD_W'(phaseSum - {1'b0, refPeriod_reg});
      vcoHalf_reg  <= 1'b1;
    end else begin
      phaseAcc_reg <= phaseSum[PERIOD_W-1:0];
      vcoHalf_reg  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // post-scale counters
  // ----------------------------------------------------------------
  // each output toggles every C half periods: one output period per C oscillator periods
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        postCount_reg[i] <= '0;
      end
      outLevel_reg <= '0;
      extLevel_reg <= 1'b0;
    end else if (holdOff) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        postCount_reg[i] <= '0;
      end
      outLevel_reg <= '0;
      extLevel_reg <= 1'b0;
    end else if (vcoHalf_reg) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        if (postCount_reg[i] == POST_SET[i] - 6'h01) begin
          postCount_reg[i] <= '0;
          outLevel_reg[i]  <= !outLevel_reg[i];
        end else begin
          postCount_reg[i] <= postCount_reg[i] + 6'h01;
        end
      end
      // external pin twins the third output from its own flop
      if (postCount_reg[2] == POST_SET[2] - 6'h01) begin
        extLevel_reg <= !outLevel_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // lock detect
  // ----------------------------------------------------------------
  // lock is granted after a fixed run of reference ticks, restarted by a hold-off or a switchover
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockState_reg <= LOCK_OFF;
      lockCount_reg <= '0;
      lock_reg      <= 1'b0;
    end else if (holdOff) begin
      lockState_reg <= LOCK_OFF;
      lockCount_reg <= '0;
      lock_reg      <= 1'b0;
    end else begin
      case (lockState_reg)
        LOCK_OFF: begin
          lockState_reg <= LOCK_ACQUIRE;
          lockCount_reg <= '0;
          lock_reg      <= 1'b0;
        end
        LOCK_ACQUIRE: begin
          if (switchEvent) begin
            lockCount_reg <= '0;
          end else if (refTick && refPeriod_reg != '0) begin
            if (lockCount_reg == LOCK_LAST) begin
              lockState_reg <= LOCK_LOCKED;
              lock_reg      <= 1'b1;
            end else begin
              lockCount_reg <= lockCount_reg + 8'h01;
            end
          end
        end
        LOCK_LOCKED: begin
          // a new source means the loop is out of lock until it settles again
          if (switchEvent) begin
            lockState_reg <= LOCK_ACQUIRE;
            lockCount_reg <= '0;
            lock_reg      <= 1'b0;
          end
        end
        default: begin
          lockState_reg <= LOCK_OFF;
          lock_reg      <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.lockIndicator = lock_reg;
  assign link.scaledOutZero = outLevel_reg[0];
  assign link.scaledOutOne  = outLevel_reg[1];
  assign link.scaledOutTwo  = outLevel_reg[2];
  assign extClkOut          = extLevel_reg;
  assign refSelSecondary    = refSel_reg;

endmodule

`default_nettype wire

// file: design/plc_user_end.sv
`default_nettype none

module plc_user_end
  import plc_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     rst_n,
  input  wire logic     userEnable,
  input  wire logic     userClear,
  input  wire logic     userRefLost,
  input  wire logic     userSwitch,
  plc_link_if.user      link,
  output logic          clocksStable
);

  localparam logic [STABLE_W-1:0] STABLE_LAST = STABLE_W'(STABLE_CYCLES - 1);

  logic                pllEnable_reg;
  logic                counterClear_reg;
  logic                pfdEnable_reg;
  logic                switchRequest_reg;
  logic [STABLE_W-1:0] stableCount_reg;
  logic                stable_reg;

  // ----------------------------------------------------------------
  // control drive
  // ----------------------------------------------------------------
  // registered so the device sees clean same-clock levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pllEnable_reg     <= 1'b0;
      counterClear_reg  <= 1'b1;
      pfdEnable_reg     <= 1'b0;
      switchRequest_reg <= 1'b0;
    end else begin
      pllEnable_reg     <= userEnable;
      counterClear_reg  <= userClear;
      pfdEnable_reg     <= !userRefLost;
      switchRequest_reg <= userSwitch;
    end
  end

  // ----------------------------------------------------------------
  // lock qualification
  // ----------------------------------------------------------------
  // lock may chatter while acquiring; trust it only after a steady run
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stableCount_reg <= '0;
      stable_reg      <= 1'b0;
    end else if (!link.lockIndicator) begin
      stableCount_reg <= '0;
      stable_reg      <= 1'b0;
    end else if (stableCount_reg == STABLE_LAST) begin
      stable_reg      <= 1'b1;
    end else begin
      stableCount_reg <= stableCount_reg + 8'h01;
    end
  end

  assign link.pllEnable     = pllEnable_reg;
  assign link.counterClear  = counterClear_reg;
  assign link.pfdEnable     = pfdEnable_reg;
  assign link.switchRequest = switchRequest_reg;
  assign clocksStable       = stable_reg;

endmodule

`default_nettype wire

// file: testbench/plc_link_assertions.sv
`default_nettype none

module plc_link_assertions
  import plc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pllEnable,
  input wire logic counterClear,
  input wire logic switchRequest,
  input wire logic lockIndicator,
  input wire logic scaledOutZero,
  input wire logic scaledOutOne,
  input wire logic scaledOutTwo,
  input wire logic extClkOut,
  input wire logic refSelSecondary
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  // half period of the fastest output in the bench is far below this
  localparam int         ALIVE_MAX = 200;
  // each reference tick needs at least two cycles through the pin sync
  localparam logic [7:0] MIN_RUN   = 8'(2 * LOCK_REF_CYCLES);

  logic [7:0] runCnt_reg;

  // cycles since the loop was last held off, saturating
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      runCnt_reg <= 8'h00;
    end else if (!pllEnable || counterClear) begin
      runCnt_reg <= 8'h00;
    end else if (runCnt_reg != 8'hff) begin
      runCnt_reg <= runCnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence all_low_s;
    !scaledOutZero && !scaledOutOne && !scaledOutTwo && !extClkOut;
  endsequence

  sequence switch_rise_s;
    $rose(switchRequest) && pllEnable && !counterClear;
  endsequence

  enable_lock_low_a: assert property (!pllEnable |=> !lockIndicator)
    else $error("lock stayed high with the loop disabled");
  enable_outs_low_a: assert property (!pllEnable |=> all_low_s)
    else $error("outputs not held low with the loop disabled");
  clear_lock_low_a: assert property (counterClear |=> !lockIndicator)
    else $error("lock stayed high during counter clear");
  clear_outs_low_a: assert property (counterClear |=> all_low_s)
    else $error("outputs not cleared during counter clear");
  ext_pin_copy_a: assert property (extClkOut == scaledOutTwo)
    else $error("external pin differs from third output");
  switch_lock_drop_a: assert property (switch_rise_s |=> !lockIndicator)
    else $error("lock kept across a switchover");
  switch_source_a: assert property (switch_rise_s |=> refSelSecondary != $past(refSelSecondary))
    else $error("reference source did not change on switchover");
  lock_not_early_a: assert property ($rose(lockIndicator) |-> runCnt_reg >= MIN_RUN)
    else $error("lock rose too soon after hold-off");
  outs_alive_a: assert property (disable iff (!rst_n || !pllEnable || counterClear || switchRequest)
    lockIndicator |-> ##[1:ALIVE_MAX] $changed(scaledOutZero))
    else $error("first output stopped toggling");
endmodule

`default_nettype wire

// file: testbench/tb_pll_control_status_ports.sv
`default_nettype none

module tb_pll_control_status_ports;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // settings and signals
  // ----------------------------------------------------------------
  localparam int M = 4;
  localparam int N = 1;
  localparam int POST0 = 2;
  localparam int POST1 = 4;
  localparam int POST2 = 8;
  localparam int REF_HALF = 20;
  localparam int SEC_HALF = 24;
  localparam int WIN = 800;

  logic sys_clk;
  logic rst_n;
  logic userEnable;
  logic userClear;
  logic userRefLost;
  logic userSwitch;
  logic refPri;
  logic refSec;
  logic refRun;
  logic extClkOut;
  logic refSelSecondary;
  logic clocksStable;
  int   refCntA;
  int   refCntB;
  int   miscompares;
  int   nTests;

  plc_link_if i_plc_link_if ();

  plc_device_end #(.MULT_SETTING(M), .PRE_SETTING(N), .POST0_SETTING(POST0), .POST1_SETTING(POST1),
                   .POST2_SETTING(POST2)) i_plc_device_end (
    .sys_clk(sys_clk), .rst_n(rst_n), .refClkPrimaryPin(refPri), .refClkSecondaryPin(refSec),
    .link(i_plc_link_if.device), .extClkOut(extClkOut), .refSelSecondary(refSelSecondary));

  plc_user_end i_plc_user_end (
    .sys_clk(sys_clk), .rst_n(rst_n), .userEnable(userEnable), .userClear(userClear),
    .userRefLost(userRefLost), .userSwitch(userSwitch), .link(i_plc_link_if.user),
    .clocksStable(clocksStable));

  plc_link_assertions i_plc_link_assertions (
    .sys_clk(sys_clk), .rst_n(rst_n), .pllEnable(i_plc_link_if.pllEnable),
    .counterClear(i_plc_link_if.counterClear), .switchRequest(i_plc_link_if.switchRequest),
    .lockIndicator(i_plc_link_if.lockIndicator), .scaledOutZero(i_plc_link_if.scaledOutZero),
    .scaledOutOne(i_plc_link_if.scaledOutOne), .scaledOutTwo(i_plc_link_if.scaledOutTwo),
    .extClkOut(extClkOut), .refSelSecondary(refSelSecondary));

  // ----------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;

  // dedicated reference pins; they stand still when the source is lost
  always @(posedge sys_clk) begin
    if (refRun) begin
      refCntA <= (refCntA + 1) % REF_HALF;
      refCntB <= (refCntB + 1) % SEC_HALF;
      if (refCntA == REF_HALF - 1) refPri <= ~refPri;
      if (refCntB == SEC_HALF - 1) refSec <= ~refSec;
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // step past the edge so the design's updates have landed
  task automatic waitCycles(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic got, input logic exp, input string what);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic waitLock(input int limit);
    int k;
    k = 0;
    while (i_plc_link_if.lockIndicator !== 1'b1 && k < limit) begin
      @(posedge sys_clk);
      k++;
    end
    #1;
    check(i_plc_link_if.lockIndicator, 1'b1, "lock not reached");
  endtask

  task automatic checkIdle(input string what);
    check(i_plc_link_if.lockIndicator, 1'b0, what);
    check(i_plc_link_if.scaledOutZero, 1'b0, what);
    check(i_plc_link_if.scaledOutOne, 1'b0, what);
    check(i_plc_link_if.scaledOutTwo, 1'b0, what);
    check(extClkOut, 1'b0, what);
  endtask

  function automatic int edges(input int c, input int half);
    return WIN * M / (2 * half * N * c);
  endfunction

  // rising edges of each output over a window, one edge of slack for phase
  task automatic checkRates(input int half);
    int cnt [3];
    int exp [3];
    logic [2:0] cur;
    logic [2:0] prev;
    cnt = '{0, 0, 0};
    exp = '{edges(POST0, half), edges(POST1, half), edges(POST2, half)};
    prev = 3'h0;
    repeat (WIN) begin
      @(posedge sys_clk);
      cur = {i_plc_link_if.scaledOutTwo, i_plc_link_if.scaledOutOne, i_plc_link_if.scaledOutZero};
      for (int j = 0; j < 3; j++) if (cur[j] === 1'b1 && prev[j] === 1'b0) cnt[j]++;
      prev = cur;
    end
    for (int j = 0; j < 3; j++) begin
      nTests++;
      if (cnt[j] < exp[j] - 1 || cnt[j] > exp[j] + 1) begin
        miscompares++;
        $display("[ERR] %0t output %0d rate %0d edges, want %0d", $time, j, cnt[j], exp[j]);
      end
    end
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    {userEnable, userClear, userRefLost, userSwitch} = 4'h0;
    {refPri, refSec, refRun} = 3'h1;
    refCntA = 0;
    refCntB = 0;
    miscompares = 0;
    nTests = 0;
    waitCycles(3);
    check(i_plc_link_if.pllEnable, 1'b0, "enable in reset");
    check(i_plc_link_if.counterClear, 1'b1, "clear in reset");
    checkIdle("outputs in reset");
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    userEnable <= 1'b1;
    waitCycles(100);
    check(i_plc_link_if.lockIndicator, 1'b0, "lock too early");
    waitLock(2000);
    waitCycles(40);
    check(clocksStable, 1'b1, "clocks not qualified");
    checkRates(REF_HALF);
    // switch over to the secondary source and back again
    for (int s = 0; s < 2; s++) begin
      @(posedge sys_clk);
      userSwitch <= 1'b1;
      waitCycles(3);
      check(refSelSecondary, s == 0, "source select");
      check(i_plc_link_if.lockIndicator, 1'b0, "lock across switch");
      @(posedge sys_clk);
      userSwitch <= 1'b0;
      waitLock(2500);
      checkRates(s == 0 ? SEC_HALF : REF_HALF);
    end
    @(posedge sys_clk);
    userClear <= 1'b1;
    waitCycles(3);
    checkIdle("clear start");
    waitCycles(50);
    checkIdle("clear held");
    @(posedge sys_clk);
    userClear <= 1'b0;
    waitLock(2000);
    // source lost: detector off, outputs must keep their rate
    @(posedge sys_clk);
    userRefLost <= 1'b1;
    refRun <= 1'b0;
    waitCycles(3);
    check(i_plc_link_if.pfdEnable, 1'b0, "detector still on");
    checkRates(REF_HALF);
    // a live source with the detector off must not retune: move to the slower one
    @(posedge sys_clk);
    refRun <= 1'b1;
    userSwitch <= 1'b1;
    waitCycles(3);
    @(posedge sys_clk);
    userSwitch <= 1'b0;
    checkRates(REF_HALF);
    @(posedge sys_clk);
    userSwitch <= 1'b1;
    @(posedge sys_clk);
    userSwitch <= 1'b0;
    waitCycles(3);
    check(refSelSecondary, 1'b0, "source not restored");
    @(posedge sys_clk);
    userRefLost <= 1'b0;
    refRun <= 1'b1;
    @(posedge sys_clk);
    userEnable <= 1'b0;
    waitCycles(3);
    checkIdle("disabled");
    @(posedge sys_clk);
    userEnable <= 1'b1;
    waitLock(2000);
    print_verdict();
  end

  // the whole sequence needs well under 15000 cycles
  initial begin
    #300000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule

`default_nettype wire
